// [design/fsp_pkg.sv]
package fsp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE_KEY = 8'h00;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_ADDR_H = 8'h0C;
  localparam logic [7:0] OFS_ADDR_L = 8'h10;
  localparam logic [7:0] OFS_CMP_H = 8'h14;
  localparam logic [7:0] OFS_CMP_L = 8'h18;
  localparam logic [7:0] OFS_WDATA = 8'h1C;
  localparam logic [7:0] OFS_PROTECT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_SECURITY = 8'h28;
  localparam logic [7:0] OFS_RDATA = 8'h2C;
  // status field positions
  localparam int ST_PROT_ERR = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SELF = 2;
  localparam int ST_SEC = 3;
  localparam int ST_FAIL = 4;
  localparam int ST_SEC_ERR = 5;
  // key that must precede a mode control write
  localparam logic [7:0] MODE_KEY_VAL = 8'hA5;
  // command codes
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_BLANK = 8'h08;
  // reset and blank values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ERASE_VALUE = 8'hFF;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int HALT_MAX_NS = 10000;
  localparam int HALT_EXTRA_CLK = 2;
  localparam int HALT_REL_CYC = HALT_MAX_NS / CLK_PERIOD_NS + HALT_EXTRA_CLK;
  localparam int HALT_CNT_W = 12;

  // operations passed to the flash macro
  typedef enum logic [1:0] {
    FSP_OP_READ = 2'b00,
    FSP_OP_WRITE = 2'b01,
    FSP_OP_ERASE = 2'b10,
    FSP_OP_BLANK = 2'b11
  } fsp_op_t;

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_RUN = 2'b01,
    FSP_CHECK = 2'b10
  } fsp_fsm_t;

  // one register write, valid for one cycle
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } fsp_bus_wr_t;

  // request to the flash macro, held until ack
  typedef struct packed {
    logic req;
    fsp_op_t op;
    logic [12:0] addr;
    logic [7:0] wdata;
  } fsp_flash_req_t;

  // answer from the flash macro
  typedef struct packed {
    logic ack;
    logic fail;
    logic [7:0] rdata;
  } fsp_flash_rsp_t;
endpackage

// [design/fsp_sync.sv]
`timescale 1ns/1ns
// three-stage pin synchroniser; output moves once stages two and three agree
module fsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } fsp_sync_t;
  fsp_sync_t q, d;

  // s1 is read only by s2
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.out = q.s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= {4{RST_VAL}};
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.out;
endmodule

// [design/fsp_ahb_slave.sv]
`timescale 1ns/1ns
// zero-wait ahb-lite slave: reads sampled at address phase, writes in data phase
module fsp_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  output fsp_pkg::fsp_bus_wr_t bus_wr
);
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } fsp_ahb_t;
  fsp_ahb_t q, d;
  logic take;

  // only word transfers are used; hsize is accepted without check
  assign take = hsel && hready && htrans[1];
  assign rd_addr = haddr[7:0];

  always_comb begin
    d = q;
    d.wr_pend = 1'b0;
    if (take) begin
      d.wr_pend = hwrite;
      d.wr_addr = haddr[7:0];
      // unmapped offsets return zero through the decoder
      d.rdata = hwrite ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign bus_wr.en = q.wr_pend;
  assign bus_wr.addr = q.wr_addr;
  assign bus_wr.data = hwdata;
endmodule

// [design/fsp_ctrl.sv]
`timescale 1ns/1ns
// Function
// - security blocks every erase in external programming
// - secured write cannot change stored data
// - cpu stalled while command runs
// - interrupts held pending until normal mode
// - no ram access during a command
// - block erase leaves every byte ffh
// - halt released within 10 us plus 2
// - pins held as in halt state
// - self programming ignores external security
// - protect byte suppresses self-mode write and erase
// - no interrupt serviced in self mode
// - reset during write or erase unguaranteed
module fsp_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_prog_pin,
  input wire logic cpu_halt,
  output logic halt_release,
  output logic cpu_stall,
  output logic ram_block,
  output logic irq_hold,
  output logic pin_hold,
  output fsp_pkg::fsp_flash_req_t flash_req,
  input wire fsp_pkg::fsp_flash_rsp_t flash_rsp
);
  // whole block state in one record
  typedef struct packed {
    // mode entry: key seen, self mode on
    logic key_ok;
    logic self_mode;
    // firmware registers, low byte only
    logic [7:0] cmd;
    logic [7:0] addr_h;
    logic [7:0] addr_l;
    logic [7:0] cmp_h;
    logic [7:0] cmp_l;
    logic [7:0] wdata;
    logic [7:0] protect;
    logic [7:0] rdata;
    // sticky flags, hardware sets, write one clears; sec_set is set by a write and cleared by reset only
    logic prot_err;
    logic sec_err;
    logic fail;
    logic sec_set;
    // sequencer, release timer, macro request
    fsp_pkg::fsp_fsm_t fsm;
    logic halt_arm;
    logic [fsp_pkg::HALT_CNT_W-1:0] halt_cnt;
    logic halt_rel;
    fsp_pkg::fsp_flash_req_t freq;
  } fsp_ctrl_t;

  // timer starts at zero and the pulse leaves a flop,
  // so the last count is one short of the release time
  localparam logic [fsp_pkg::HALT_CNT_W-1:0] HALT_LAST =
    fsp_pkg::HALT_CNT_W'(fsp_pkg::HALT_REL_CYC - 1);

  fsp_ctrl_t q, d;
  fsp_pkg::fsp_bus_wr_t bus_wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic ext_prog; // programmer attached, synchronised
  logic [12:0] cmd_addr; // byte address from the pointers
  logic [7:0] status;

  // external programming mode strap arrives on a pin
  // it may move at any time, hence the full synchroniser
  fsp_sync #(
    .RST_VAL(1'b0)
  ) u_sync_ext (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(ext_prog_pin),
    .sync_out(ext_prog)
  );

  // register bus
  // zero wait: every request answered in the next cycle
  fsp_ahb_slave u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .bus_wr(bus_wr)
  );

  // bits 5-7 of the high pointer are ignored, firmware keeps them clear
  // a stray set bit is dropped so it cannot reach a wrong block
  assign cmd_addr = {q.addr_h[4:0], q.addr_l};

  // protect byte: one bit guards four blocks of the 32
  // erase checks the pointer block, so keep compare equal to it
  function automatic logic is_protected(input logic [7:0] prot,
                                        input logic [7:0] hi);
    is_protected = prot[hi[4:2]];
  endfunction

  // write and erase are the commands that alter the array
  function automatic logic is_alter(input logic [7:0] c);
    is_alter = (c == fsp_pkg::CMD_WRITE) || (c == fsp_pkg::CMD_ERASE);
  endfunction

  // any state but idle means a command owns the macro
  function automatic logic is_busy(input fsp_pkg::fsp_fsm_t s);
    is_busy = (s != fsp_pkg::FSP_IDLE);
  endfunction

  // status word assembled from live state
  // busy mirrors the stall, so firmware can poll it after a wake
  always_comb begin
    status = 8'h00;
    status[fsp_pkg::ST_PROT_ERR] = q.prot_err;
    status[fsp_pkg::ST_BUSY] = is_busy(q.fsm);
    status[fsp_pkg::ST_SELF] = q.self_mode;
    status[fsp_pkg::ST_SEC] = q.sec_set;
    status[fsp_pkg::ST_FAIL] = q.fail;
    status[fsp_pkg::ST_SEC_ERR] = q.sec_err;
  end

  // read decode; unmapped offsets answer zero
  // key register is write-only, a read never shows the key
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      fsp_pkg::OFS_MODE_CTRL: rd_data[0] = q.self_mode;
      fsp_pkg::OFS_CMD: rd_data[7:0] = q.cmd;
      fsp_pkg::OFS_ADDR_H: rd_data[7:0] = q.addr_h;
      fsp_pkg::OFS_ADDR_L: rd_data[7:0] = q.addr_l;
      fsp_pkg::OFS_CMP_H: rd_data[7:0] = q.cmp_h;
      fsp_pkg::OFS_CMP_L: rd_data[7:0] = q.cmp_l;
      fsp_pkg::OFS_WDATA: rd_data[7:0] = q.wdata;
      fsp_pkg::OFS_PROTECT: rd_data[7:0] = q.protect;
      fsp_pkg::OFS_STATUS: rd_data[7:0] = status;
      fsp_pkg::OFS_SECURITY: rd_data[0] = q.sec_set;
      fsp_pkg::OFS_RDATA: rd_data[7:0] = q.rdata;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // next state: register writes, halt release, command sequencer
  always_comb begin
    d = q;
    d.halt_rel = 1'b0;

    // software side; the cpu is stalled while busy so no writes arrive then
    // a write that slips in mid-command still lands
    if (bus_wr.en) begin
      // key only counts for the very next write
      d.key_ok = 1'b0;
      unique case (bus_wr.addr)
        fsp_pkg::OFS_MODE_KEY: begin
          d.key_ok = (bus_wr.data[7:0] == fsp_pkg::MODE_KEY_VAL);
        end
        fsp_pkg::OFS_MODE_CTRL: begin
          // mode changes only after the key, guarding stray writes
          if (q.key_ok) begin
            d.self_mode = bus_wr.data[0];
            // entry arms the automatic release of the next halt
            d.halt_arm = bus_wr.data[0];
            d.halt_cnt = '0;
          end
        end
        fsp_pkg::OFS_CMD: d.cmd = bus_wr.data[7:0];
        fsp_pkg::OFS_ADDR_H: d.addr_h = bus_wr.data[7:0];
        fsp_pkg::OFS_ADDR_L: d.addr_l = bus_wr.data[7:0];
        fsp_pkg::OFS_CMP_H: d.cmp_h = bus_wr.data[7:0];
        fsp_pkg::OFS_CMP_L: d.cmp_l = bus_wr.data[7:0];
        fsp_pkg::OFS_WDATA: d.wdata = bus_wr.data[7:0];
        fsp_pkg::OFS_PROTECT: d.protect = bus_wr.data[7:0];
        fsp_pkg::OFS_STATUS: begin
          // write one to clear; a same-cycle set below still wins
          if (bus_wr.data[fsp_pkg::ST_PROT_ERR]) begin
            d.prot_err = 1'b0;
          end
          if (bus_wr.data[fsp_pkg::ST_FAIL]) begin
            d.fail = 1'b0;
          end
          if (bus_wr.data[fsp_pkg::ST_SEC_ERR]) begin
            d.sec_err = 1'b0;
          end
        end
        fsp_pkg::OFS_SECURITY: begin
          // set-once, only by the external programmer; reset alone clears
          if (ext_prog && bus_wr.data[0]) begin
            d.sec_set = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // automatic halt release after the fixed worst-case time
    // only halted cycles count; an early wake pauses the timer
    // rather than restarting it, a simpler counter for less accuracy
    if (q.halt_arm && cpu_halt) begin
      if (q.halt_cnt == HALT_LAST) begin
        d.halt_rel = 1'b1;
        d.halt_arm = 1'b0;
        d.halt_cnt = '0;
      end else begin
        d.halt_cnt = q.halt_cnt + 1'b1;
      end
    end

    // command sequencer
    unique case (q.fsm)
      fsp_pkg::FSP_IDLE: begin
        // a command starts on the write of a nonzero code in self mode or with the programmer attached
        // refusals below undo the start, nothing reaches the macro
        if (bus_wr.en && bus_wr.addr == fsp_pkg::OFS_CMD &&
            bus_wr.data[7:0] != fsp_pkg::CMD_NONE && (q.self_mode || ext_prog)) begin
          d.freq.addr = cmd_addr;
          d.freq.wdata = q.wdata;
          d.freq.req = 1'b1;
          d.fsm = fsp_pkg::FSP_RUN;
          unique case (bus_wr.data[7:0])
            fsp_pkg::CMD_WRITE: d.freq.op = fsp_pkg::FSP_OP_WRITE;
            fsp_pkg::CMD_ERASE: begin
              // whole block from its first byte, filled with the blank value
              d.freq.op = fsp_pkg::FSP_OP_ERASE;
              d.freq.addr = {q.cmp_h[4:0], 8'h00};
              d.freq.wdata = fsp_pkg::ERASE_VALUE;
            end
            fsp_pkg::CMD_VERIFY: d.freq.op = fsp_pkg::FSP_OP_READ;
            fsp_pkg::CMD_BLANK: d.freq.op = fsp_pkg::FSP_OP_BLANK;
            default: begin
              // unknown code: nothing to run
              d.freq.req = 1'b0;
              d.fsm = fsp_pkg::FSP_IDLE;
            end
          endcase
          if (q.self_mode && is_alter(bus_wr.data[7:0]) &&
              is_protected(q.protect, q.addr_h)) begin
            // only the protect byte gates self programming, security does not
            d.prot_err = 1'b1;
            d.freq.req = 1'b0;
            d.fsm = fsp_pkg::FSP_IDLE;
          end else if (!q.self_mode && q.sec_set &&
                       bus_wr.data[7:0] == fsp_pkg::CMD_ERASE) begin
            // batch-erase security refuses external erase outright
            d.sec_err = 1'b1;
            d.freq.req = 1'b0;
            d.fsm = fsp_pkg::FSP_IDLE;
          end else if (!q.self_mode && q.sec_set &&
                       bus_wr.data[7:0] == fsp_pkg::CMD_WRITE) begin
            // read back first; only an identical byte may be written
            d.freq.op = fsp_pkg::FSP_OP_READ;
            d.fsm = fsp_pkg::FSP_CHECK;
          end
        end
      end
      fsp_pkg::FSP_RUN: begin
        // cpu and ram stay blocked until the macro answers
        // no timeout here: the macro takes as long as it needs
        if (flash_rsp.ack) begin
          d.freq.req = 1'b0;
          d.fsm = fsp_pkg::FSP_IDLE;
          d.rdata = flash_rsp.rdata;
          if (flash_rsp.fail) begin
            d.fail = 1'b1;
          end
          // verify compares against the expected byte
          if (q.freq.op == fsp_pkg::FSP_OP_READ && flash_rsp.rdata != q.wdata) begin
            d.fail = 1'b1;
          end
        end
      end
      fsp_pkg::FSP_CHECK: begin
        // programming only clears bits, so a differing byte
        // could not be undone while erase is locked
        if (flash_rsp.ack) begin
          d.rdata = flash_rsp.rdata;
          if (flash_rsp.rdata == q.wdata) begin
            // same data: write is harmless, go ahead
            d.freq.op = fsp_pkg::FSP_OP_WRITE;
            d.fsm = fsp_pkg::FSP_RUN;
          end else begin
            d.sec_err = 1'b1;
            d.freq.req = 1'b0;
            d.fsm = fsp_pkg::FSP_IDLE;
          end
        end
      end
      default: begin
        // unused state code: drop the request, back to idle
        d.freq.req = 1'b0;
        d.fsm = fsp_pkg::FSP_IDLE;
      end
    endcase
  end

  // reset aborts any running operation; array contents then undefined
  // the macro sees the request fall at once, mid-operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // cpu fetch and ram port are frozen for the whole command
  // both are a decode of the two state flops, not flops of their own
  assign cpu_stall = is_busy(q.fsm);
  assign ram_block = is_busy(q.fsm);
  // interrupts stay pending while in self mode
  assign irq_hold = q.self_mode;
  // port drivers keep the halt-state levels
  // port logic freezes its drivers on this level, as in halt
  assign pin_hold = q.self_mode;
  assign halt_release = q.halt_rel;
  assign flash_req = q.freq;
endmodule

// [testbench/fsp_ctrl_properties.sv]
`timescale 1ns/1ns
// watches the top ports of the self programming controller
module fsp_ctrl_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cpu_halt,
  input wire logic halt_release,
  input wire logic cpu_stall,
  input wire logic ram_block,
  input wire logic irq_hold,
  input wire logic pin_hold,
  input wire fsp_pkg::fsp_flash_req_t flash_req,
  input wire fsp_pkg::fsp_flash_rsp_t flash_rsp
);
  localparam int HR_MIN = 2498; // release window, slack for the registered pulse
  localparam int HR_MAX = 2506;
  logic [11:0] hcnt_q; // halted cycles since mode entry or the last release
  logic [11:0] hcnt_d;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // count halted cycles in self mode, restart on release or mode exit
  always_comb begin
    hcnt_d = hcnt_q;
    if (!irq_hold || halt_release) hcnt_d = 12'h000;
    else if (cpu_halt) hcnt_d = hcnt_q + 12'h001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hcnt_q <= 12'h000;
    else hcnt_q <= hcnt_d;
  end
  property p_stall; flash_req.req == cpu_stall; endproperty
  a_stall: assert property (p_stall) else $error("stall differs from request");
  property p_ram; ram_block == cpu_stall; endproperty
  a_ram: assert property (p_ram) else $error("ram block differs from stall");
  property p_pin; pin_hold == irq_hold; endproperty
  a_pin: assert property (p_pin) else $error("pin hold differs from irq hold");
  property p_rel_self; halt_release |-> irq_hold; endproperty
  a_rel_self: assert property (p_rel_self) else $error("release outside self mode");
  property p_rel_early; halt_release |-> hcnt_q >= HR_MIN; endproperty
  a_rel_early: assert property (p_rel_early) else $error("halt released too early");
  property p_rel_late; hcnt_q <= HR_MAX; endproperty
  a_rel_late: assert property (p_rel_late) else $error("halt released too late");
  property p_req_hold; flash_req.req && !flash_rsp.ack |=> flash_req.req && $stable(flash_req); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  // a secured read-back that matches goes straight on to the write
  property p_req_drop; flash_rsp.ack |=> !flash_req.req && !cpu_stall ||
    flash_req.req && flash_req.op == fsp_pkg::FSP_OP_WRITE &&
    $past(flash_req.op) == fsp_pkg::FSP_OP_READ; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_erase; flash_req.req && flash_req.op == fsp_pkg::FSP_OP_ERASE |->
    flash_req.wdata == fsp_pkg::ERASE_VALUE && flash_req.addr[7:0] == 8'h00; endproperty
  a_erase: assert property (p_erase) else $error("erase not blank value");
endmodule

bind fsp_ctrl fsp_ctrl_properties u_fsp_ctrl_properties (
  .hclk(hclk), .hresetn(hresetn), .cpu_halt(cpu_halt), .halt_release(halt_release),
  .cpu_stall(cpu_stall), .ram_block(ram_block), .irq_hold(irq_hold), .pin_hold(pin_hold),
  .flash_req(flash_req), .flash_rsp(flash_rsp)
);

// [testbench/fsp_flash_model.sv]
`timescale 1ns/1ns
// behavioural flash array behind the macro port
module fsp_flash_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire fsp_pkg::fsp_flash_req_t flash_req,
  output fsp_pkg::fsp_flash_rsp_t flash_rsp
);
  logic [7:0] mem_q [0:8191]; // keeps contents over reset, like real flash
  logic [2:0] wait_q; // cycles left before the answer
  logic done_q; // answered on the last edge, cleared on the next one
  logic blank; // block check result
  initial begin
    for (int i = 0; i < 8192; i++) mem_q[i] = 8'hFF;
  end
  // one answer per request after a random latency of 1 to 5 cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_rsp <= '0;
      wait_q <= 3'h2;
      done_q <= 1'b0;
    end else begin
      flash_rsp.ack <= 1'b0;
      flash_rsp.rdata <= ~flash_rsp.rdata; // no stale data outside the ack
      flash_rsp.fail <= ~flash_rsp.fail;
      if (!flash_req.req || done_q) begin
        // request may still stand after an answer; a changed one is new work
        done_q <= 1'b0;
        wait_q <= 3'($urandom_range(4, 0));
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else begin
        done_q <= 1'b1;
        flash_rsp.ack <= 1'b1;
        flash_rsp.rdata <= mem_q[flash_req.addr];
        blank = 1'b1;
        for (int i = 0; i < 256; i++) begin
          if (mem_q[{flash_req.addr[12:8], 8'(i)}] !== 8'hFF) blank = 1'b0;
        end
        flash_rsp.fail <= (flash_req.op == fsp_pkg::FSP_OP_BLANK) && !blank;
        // programming can only clear bits
        if (flash_req.op == fsp_pkg::FSP_OP_WRITE) begin
          mem_q[flash_req.addr] <= mem_q[flash_req.addr] & flash_req.wdata;
        end
        if (flash_req.op == fsp_pkg::FSP_OP_ERASE) begin
          for (int i = 0; i < 256; i++) mem_q[{flash_req.addr[12:8], 8'(i)}] <= 8'hFF;
        end
      end
    end
  end
endmodule

// [testbench/flash_self_program_control_tb.sv]
`timescale 1ns/1ns
module flash_self_program_control_tb;
  logic hclk, hresetn, hsel, hwrite, hready, ext_prog_pin, cpu_halt;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, halt_release, cpu_stall, ram_block, irq_hold, pin_hold;
  fsp_pkg::fsp_flash_req_t flash_req;
  fsp_pkg::fsp_flash_rsp_t flash_rsp;
  int n_errors, checks;
  logic [4:0] blk; // block under test
  logic [7:0] lo, dat; // byte address and data under test
  assign hready = hreadyout; // single slave drives the bus ready
  fsp_ctrl u_fsp_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_prog_pin(ext_prog_pin),
    .cpu_halt(cpu_halt), .halt_release(halt_release), .cpu_stall(cpu_stall),
    .ram_block(ram_block), .irq_hold(irq_hold), .pin_hold(pin_hold),
    .flash_req(flash_req), .flash_rsp(flash_rsp));
  fsp_flash_model u_fsp_flash_model (.hclk(hclk), .hresetn(hresetn),
    .flash_req(flash_req), .flash_rsp(flash_rsp));
  // 250 mhz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    if (n >= 40) begin n_errors++; end_sim(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(nm, r, e);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  // issue a command and see whether it ran to its end
  task automatic cmd(input logic [7:0] c, input logic run);
    int n;
    logic saw;
    saw = 1'b0;
    wr(fsp_pkg::OFS_CMD, {24'h0, c});
    for (n = 0; n < 40 && !(saw && cpu_stall === 1'b0); n++) begin
      @(posedge hclk);
      #1;
      if (cpu_stall === 1'b1) saw = 1'b1;
    end
    chk("cmd_run", {31'h0, saw}, {31'h0, run});
    if (n >= 40 && run) begin n_errors++; end_sim(); end
    @(posedge hclk);
  endtask
  task automatic mode(input logic on);
    wr(fsp_pkg::OFS_CMD, 32'h0);
    wr(fsp_pkg::OFS_MODE_KEY, {24'h0, fsp_pkg::MODE_KEY_VAL});
    wr(fsp_pkg::OFS_MODE_CTRL, {31'h0, on});
  endtask
  // nop then halt, cpu wakes on the release pulse
  task automatic halt_seq();
    int n;
    repeat (2) @(posedge hclk);
    cpu_halt <= 1'b1;
    for (n = 0; n < 3000 && halt_release !== 1'b1; n++) begin
      @(posedge hclk);
      #1;
    end
    chk("halt_release", {31'h0, n >= 2498 && n <= 2506}, 32'h1);
    chk("self_hold", {30'h0, irq_hold, pin_hold}, 32'h3);
    @(posedge hclk);
    cpu_halt <= 1'b0;
    repeat (2000) @(posedge hclk);
  endtask
  function automatic logic blank_ok(input logic [4:0] b);
    blank_ok = 1'b1;
    for (int i = 0; i < 256; i++) begin
      if (u_fsp_flash_model.mem_q[{b, 8'(i)}] !== 8'hFF) blank_ok = 1'b0;
    end
  endfunction
  // hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    end_sim();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b1; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; ext_prog_pin = 1'b0; cpu_halt = 1'b0;
    n_errors = 0; checks = 0; blk = 5'h0; lo = 8'h0; dat = 8'h0;
    void'($urandom(32'hCFC963B7));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("status_rst", fsp_pkg::OFS_STATUS, 32'h0);
    rdc("unmapped", 8'h30, 32'h0);
    wr(fsp_pkg::OFS_MODE_CTRL, 32'h1);
    rdc("no_key", fsp_pkg::OFS_STATUS, 32'h0);
    mode(1'b1);
    halt_seq();
    for (int k = 0; k < 3; k++) begin
      blk = (k == 0) ? 5'h1F : 5'($urandom_range(31, 0));
      lo = (k == 0) ? 8'hFF : 8'($urandom);
      dat = 8'($urandom_range(254, 0));
      wr(fsp_pkg::OFS_PROTECT, 32'h0);
      wr(fsp_pkg::OFS_ADDR_H, {27'h0, blk});
      wr(fsp_pkg::OFS_ADDR_L, {24'h0, lo});
      wr(fsp_pkg::OFS_CMP_H, {27'h0, blk});
      wr(fsp_pkg::OFS_WDATA, {24'h0, dat});
      cmd(fsp_pkg::CMD_ERASE, 1'b1);
      chk("erased", {31'h0, blank_ok(blk)}, 32'h1);
      cmd(fsp_pkg::CMD_BLANK, 1'b1);
      rdc("blank_pass", fsp_pkg::OFS_STATUS, 32'h4);
      cmd(fsp_pkg::CMD_WRITE, 1'b1);
      chk("written", {24'h0, u_fsp_flash_model.mem_q[{blk, lo}]}, {24'h0, dat});
      cmd(fsp_pkg::CMD_VERIFY, 1'b1);
      rdc("verify", fsp_pkg::OFS_STATUS, 32'h4);
      rdc("rdata", fsp_pkg::OFS_RDATA, {24'h0, dat});
      cmd(fsp_pkg::CMD_BLANK, 1'b1);
      rdc("blank_fail", fsp_pkg::OFS_STATUS, 32'h14);
      wr(fsp_pkg::OFS_STATUS, 32'h31);
      wr(fsp_pkg::OFS_PROTECT, 32'h1 << blk[4:2]);
      cmd(fsp_pkg::CMD_ERASE, 1'b0);
      rdc("prot_err", fsp_pkg::OFS_STATUS, 32'h5);
      cmd(fsp_pkg::CMD_WRITE, 1'b0);
      chk("prot_kept", {24'h0, u_fsp_flash_model.mem_q[{blk, lo}]}, {24'h0, dat});
      wr(fsp_pkg::OFS_STATUS, 32'h31);
    end
    wr(fsp_pkg::OFS_PROTECT, 32'h0);
    mode(1'b0);
    rdc("normal", fsp_pkg::OFS_STATUS, 32'h0);
    chk("irq_free", {31'h0, irq_hold}, 32'h0);
    ext_prog_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    wr(fsp_pkg::OFS_SECURITY, 32'h1);
    rdc("secured", fsp_pkg::OFS_STATUS, 32'h8);
    cmd(fsp_pkg::CMD_ERASE, 1'b0);
    rdc("erase_refused", fsp_pkg::OFS_STATUS, 32'h28);
    wr(fsp_pkg::OFS_STATUS, 32'h31);
    wr(fsp_pkg::OFS_WDATA, {24'h0, ~dat});
    cmd(fsp_pkg::CMD_WRITE, 1'b1);
    rdc("write_refused", fsp_pkg::OFS_STATUS, 32'h28);
    chk("sec_kept", {24'h0, u_fsp_flash_model.mem_q[{blk, lo}]}, {24'h0, dat});
    wr(fsp_pkg::OFS_STATUS, 32'h31);
    wr(fsp_pkg::OFS_WDATA, {24'h0, dat});
    cmd(fsp_pkg::CMD_WRITE, 1'b1);
    rdc("same_write", fsp_pkg::OFS_STATUS, 32'h8);
    ext_prog_pin <= 1'b0;
    mode(1'b1);
    halt_seq();
    cmd(fsp_pkg::CMD_ERASE, 1'b1);
    chk("self_erase", {31'h0, blank_ok(blk)}, 32'h1);
    end_sim();
  end
endmodule
